// ==== include/ars_pkg.sv ====
package ars_pkg;
  // ******************************************
  // register map
  // ******************************************
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_BYPASS = 8'h24;
  localparam logic [7:0] ADDR_CHANNEL_B_OUTPUT_CODING = 8'h92;
  localparam int SOFT_RESET_BIT = 0;
  localparam int BYPASS_BIT = 2;
  localparam int FORMAT_B_BIT = 1;
  // ******************************************
  // values loaded from fuses on reset release
  // ******************************************
  localparam logic [7:0] FUSE_BYPASS = 8'h00;
  localparam logic [7:0] FUSE_CHANNEL_B_OUTPUT_CODING = 8'h00;
  // ******************************************
  // calibration length in sampling-clock cycles
  // ******************************************
  localparam int CAL_CYCLES = 200000;
  localparam int CAL_COUNT_W = 18;
  localparam int SAMPLE_W = 14;
  typedef enum logic [3:0] {
    ARS_HOLD = 4'b0001,
    ARS_LOAD = 4'b0010,
    ARS_CAL = 4'b0100,
    ARS_READY = 4'b1000
  } ars_state_t;
endpackage

// ==== design/ars_reset_init.sv ====
`timescale 1ns/10ps
// Overview of operation
// - channel B coding bit 1: 0 two's complement, 1 offset binary; others zero (the code stores and reads back all 8 written bits)
// - coding choice acts only while bypass bit D2 of register 0x24 is set
// - reset release loads fuse defaults then calibrates about 200000 cycles
// - writing one to bit D0 of register 0x00 resets all registers
// - the software reset bit clears itself with no further write
module ars_reset_init #(
  parameter int CAL_LENGTH = ars_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic resetPin,
  input wire logic referenceModePin,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  output logic regAccept,
  output logic configReady,
  output logic calibrating,
  output logic referenceMode,
  input wire logic [ars_pkg::SAMPLE_W-1:0] sampleB,
  output logic [ars_pkg::SAMPLE_W-1:0] dataOutB
);
  import ars_pkg::*;

  // ******************************************
  // pin synchronisers
  // ******************************************
  logic resetMeta;
  logic resetSync;
  logic refMeta;
  logic refSync;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resetMeta <= 1'b1;
      resetSync <= 1'b1;
      refMeta <= 1'b0;
      refSync <= 1'b0;
    end else begin
      resetMeta <= resetPin;
      resetSync <= resetMeta;
      refMeta <= referenceModePin;
      refSync <= refMeta;
    end
  end

  // ******************************************
  // sequencer
  // ******************************************
  ars_state_t state;
  ars_state_t next_state;
  logic [CAL_COUNT_W-1:0] calCount;
  logic [7:0] bypassReg;
  logic [7:0] codingReg;
  logic softResetBit;

  wire calDone = (calCount == CAL_COUNT_W'(CAL_LENGTH - 1));
  wire writeOk = (state == ARS_READY) && !resetSync;
  wire writeHit = regWrite && writeOk;
  wire softReset = writeHit && (regAddr == ADDR_SOFT_RESET) && regWdata[SOFT_RESET_BIT];
  wire loadDefaults = (state == ARS_LOAD);

  always_comb begin
    next_state = state;
    case (state)
      ARS_HOLD: begin
        if (!resetSync) begin
          next_state = ARS_LOAD;
        end
      end
      ARS_LOAD: begin
        next_state = ARS_CAL;
      end
      ARS_CAL: begin
        if (calDone) begin
          next_state = ARS_READY;
        end
      end
      ARS_READY: begin
        if (softReset) begin
          next_state = ARS_LOAD;
        end
      end
      default: begin
        next_state = ARS_HOLD;
      end
    endcase
    if (resetSync) begin
      next_state = ARS_HOLD;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ARS_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || state != ARS_CAL) begin
      calCount <= '0;
    end else if (!calDone) begin
      calCount <= calCount + CAL_COUNT_W'(1);
    end
  end

  // reference mode strap caught when the reset pin is released
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      referenceMode <= 1'b0;
    end else if (state == ARS_HOLD && !resetSync) begin
      referenceMode <= refSync;
    end
  end

  // ******************************************
  // registers
  // ******************************************
  always_ff @(posedge clk) begin
    if (!reset_n || loadDefaults) begin
      bypassReg <= FUSE_BYPASS;
      codingReg <= FUSE_CHANNEL_B_OUTPUT_CODING;
    end else if (writeHit && regAddr == ADDR_BYPASS) begin
      bypassReg <= regWdata;
    end else if (writeHit && regAddr == ADDR_CHANNEL_B_OUTPUT_CODING) begin
      codingReg <= regWdata;
    end
  end

  // bit shows one cycle, then clears itself
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      softResetBit <= 1'b0;
    end else begin
      softResetBit <= softReset;
    end
  end

  wire [7:0] readMux = (regAddr == ADDR_SOFT_RESET) ? {7'h00, softResetBit} :
                       (regAddr == ADDR_BYPASS) ? bypassReg :
                       (regAddr == ADDR_CHANNEL_B_OUTPUT_CODING) ? codingReg : 8'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= readMux;
    end
  end

  assign regAccept = writeOk;
  assign configReady = (state == ARS_READY);
  assign calibrating = (state == ARS_CAL);

  // ******************************************
  // channel B output coding
  // ******************************************
  wire offsetBinary = bypassReg[BYPASS_BIT] && codingReg[FORMAT_B_BIT];
  wire [SAMPLE_W-1:0] codedB = {sampleB[SAMPLE_W-1] ^ offsetBinary, sampleB[SAMPLE_W-2:0]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dataOutB <= '0;
    end else begin
      dataOutB <= codedB;
    end
  end

  // ******************************************
  // checks
  // ******************************************
  coding_offset_a: assert property (@(posedge clk) disable iff (!reset_n)
    (bypassReg[BYPASS_BIT] && codingReg[FORMAT_B_BIT]) |=>
    dataOutB[SAMPLE_W-1] != $past(sampleB[SAMPLE_W-1]))
    else $error("offset binary not applied");

  // reset_n in the antecedent skips the edge on which reset is lifted
  bypass_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && !bypassReg[BYPASS_BIT] |=> dataOutB == $past(sampleB))
    else $error("coding changed without bypass");

  fuse_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state == ARS_LOAD && !resetSync) |=> state == ARS_CAL && bypassReg == FUSE_BYPASS
    && codingReg == FUSE_CHANNEL_B_OUTPUT_CODING)
    else $error("defaults not loaded");

  cal_length_a: assert property (@(posedge clk) disable iff (!reset_n || resetSync)
    (state == ARS_CAL && !calDone) |=>
    state == ARS_CAL && calCount == $past(calCount) + CAL_COUNT_W'(1))
    else $error("calibration cut short");

  cal_done_a: assert property (@(posedge clk) disable iff (!reset_n || resetSync)
    (state == ARS_CAL && calDone) |=> configReady)
    else $error("calibration end missed");

  cal_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state == ARS_CAL && $past(state) != ARS_CAL) |-> $past(state) == ARS_LOAD)
    else $error("calibration entered without load");

  write_refused_a: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && state == ARS_CAL) |=> $stable(bypassReg) && $stable(codingReg))
    else $error("write taken during calibration");

  soft_reset_a: assert property (@(posedge clk) disable iff (!reset_n || resetSync)
    softReset |=> state == ARS_LOAD ##1 codingReg == FUSE_CHANNEL_B_OUTPUT_CODING)
    else $error("software reset did not restore defaults");

  soft_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    softReset |=> softResetBit)
    else $error("software reset bit not shown");

  self_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    softResetBit |=> !softResetBit)
    else $error("software reset bit stuck");
endmodule

// ==== testbench/ars_host_model.sv ====
`timescale 1ns/10ps
// ******************************************
// host controller: power-up strap and reset pin sequence
// ******************************************
module ars_host_model #(
  parameter int POWER_CYCLES = 8,
  parameter int WAIT_CYCLES = 24
) (
  input wire logic clk,
  output logic resetPin,
  output logic referenceModePin,
  output logic hostReady
);
  initial begin
    resetPin = 1'b0;
    referenceModePin = 1'b0;
    hostReady = 1'b0;
    // scaled power-on delay before the strap gets its level
    repeat (POWER_CYCLES) @(posedge clk);
    referenceModePin <= 1'b1;
    // 3 cycles of 40 ns exceed the strap-to-reset minimum
    repeat (3) @(posedge clk);
    resetPin <= 1'b1;
    repeat (2) @(posedge clk);
    // pin stays low from here on, also across software resets
    resetPin <= 1'b0;
    // calibration wait counted in supplied clocks plus margin
    repeat (WAIT_CYCLES) @(posedge clk);
    hostReady <= 1'b1;
  end
endmodule

// ==== testbench/ars_reset_init_tb.sv ====
`timescale 1ns/10ps
module ars_reset_init_tb;
  import ars_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [SAMPLE_W-1:0] sampleB = 14'h0123;
  logic resetPin, referenceModePin, hostReady, regAccept;
  logic configReady, calibrating, referenceMode;
  logic [7:0] regRdata;
  logic [SAMPLE_W-1:0] dataOutB;
  int error_cnt = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  ars_host_model HOST (.clk(clk), .resetPin(resetPin), .referenceModePin(referenceModePin),
    .hostReady(hostReady));
  localparam int CAL_LEN = 16;
  ars_reset_init #(.CAL_LENGTH(CAL_LEN)) DUT (.clk(clk), .reset_n(reset_n), .resetPin(resetPin),
    .referenceModePin(referenceModePin), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAccept(regAccept),
    .configReady(configReady), .calibrating(calibrating), .referenceMode(referenceMode),
    .sampleB(sampleB), .dataOutB(dataOutB));
  // ******************************************
  // access tasks
  // ******************************************
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    check(14'(regRdata), 14'(exp));
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ******************************************
  // test sequence
  // ******************************************
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 40 && calibrating !== 1'b1; i++) @(negedge clk);
    check(14'(configReady), 14'h0000);
    reg_write(ADDR_CHANNEL_B_OUTPUT_CODING, 8'h02);
    for (int i = 0; i < 100 && hostReady !== 1'b1; i++) @(negedge clk);
    check(14'(configReady), 14'h0001);
    check(14'(referenceMode), 14'h0001);
    reg_check(ADDR_CHANNEL_B_OUTPUT_CODING, FUSE_CHANNEL_B_OUTPUT_CODING);
    reg_write(ADDR_CHANNEL_B_OUTPUT_CODING, 8'h02);
    repeat (2) @(negedge clk);
    check(dataOutB, sampleB);
    reg_write(ADDR_BYPASS, 8'h04);
    repeat (2) @(negedge clk);
    check(dataOutB, sampleB ^ 14'h2000);
    // a negative sample must come out with its sign bit cleared
    @(posedge clk);
    sampleB <= 14'h2abc;
    repeat (2) @(negedge clk);
    check(dataOutB, 14'h0abc);
    reg_check(ADDR_CHANNEL_B_OUTPUT_CODING, 8'h02);
    reg_write(ADDR_SOFT_RESET, 8'h01);
    repeat (2) @(negedge clk);
    check(14'(calibrating), 14'h0001);
    // write during calibration must be ignored; it uses two of the cycles
    reg_write(ADDR_CHANNEL_B_OUTPUT_CODING, 8'h02);
    repeat (CAL_LEN - 2) @(negedge clk);
    check(14'(configReady), 14'h0000);
    @(negedge clk);
    check(14'(configReady), 14'h0001);
    reg_check(ADDR_SOFT_RESET, 8'h00);
    reg_check(ADDR_CHANNEL_B_OUTPUT_CODING, FUSE_CHANNEL_B_OUTPUT_CODING);
    reg_check(ADDR_BYPASS, FUSE_BYPASS);
    check(dataOutB, sampleB);
    reg_check(8'h55, 8'h00);
    wrap_up();
  end
  initial begin
    #(40 * 400);
    error_cnt++;
    wrap_up();
  end
endmodule
